// File: tb/cmc_ctrl_test.sv
// Self-checking testbench of the CAN mode control block
`timescale 1ns/10ps
`default_nettype none
module cmc_ctrl_test import cmc_pkg::*; ;
	logic clk = 0, rst_n = 0, rd = 0, wr = 0, spec = 0, slp = 0, st = 0;
	logic [5:0] adr = 0;
	logic [31:0] wd = 0, rdat;
	logic [7:0] pl = 0, segd, q;
	logic [2:0] rix = 0;
	logic wreq, en, csel, irq, wake, txo, bus;
	cmc_eng_in_t eng = 9'h001;
	cmc_eng_out_t eo;
	cmc_seg_wr_t sw = '0;
	int err_total = 0, n_checks = 0, nwk = 0, nrc = 0, n0;
	always #20 clk = ~clk;
	always @(posedge clk) begin
		if (wake === 1'b1) nwk++;
		if (eo.recover === 1'b1) nrc++;
	end
	cmc_ctrl #(.WUP_CYC(4)) cmc_ctrl_i (.i_mclk(clk), .i_arst_n(rst_n), .i_address(adr),
		.i_read(rd), .i_write(wr), .i_writedata(wd), .o_readdata(rdat), .o_waitrequest(wreq),
		.i_special_mode(spec), .i_sleeping(slp), .o_controller_enable(en),
		.o_clock_source_select(csel), .o_irq(irq), .o_wakeup(wake), .i_eng(eng), .o_eng(eo),
		.i_seg_wr(sw), .i_seg_rd_index(rix), .o_seg_rd_data(segd),
		.i_bus_receive_input(bus), .o_bus_transmit_output(txo));
	cmc_node_model cmc_node_model_i (.i_mclk(clk), .i_start(st), .i_len(pl), .i_dut_tx(txo),
		.o_bus_level(bus));
	// ------------------------------------------------------------
	// Bus master and helpers
	// ------------------------------------------------------------
	task chk(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task bus_op(input logic w, input logic [3:0] ix, input logic [7:0] d);
		@(posedge clk);
		adr <= {ix, 2'b00};
		rd <= !w;
		wr <= w;
		wd <= {24'h000000, d};
		// Held until waitrequest is seen low at a rising edge; data taken there
		do @(posedge clk); while (wreq !== 1'b0);
		q = rdat[7:0];
		rd <= 1'b0;
		wr <= 1'b0;
		// Mid-cycle return so callers see the write settled
		@(negedge clk);
	endtask
	task wr8(input logic [3:0] ix, input logic [7:0] d);
		bus_op(1'b1, ix, d);
	endtask
	task rdc(input logic [3:0] ix, input logic [7:0] e);
		bus_op(1'b0, ix, 8'h00);
		chk(q, e);
	endtask
	task seteng(input cmc_eng_in_t v);
		@(posedge clk);
		eng <= v;
		repeat (6) @(negedge clk);
	endtask
	task pulse(input logic [7:0] n);
		@(posedge clk);
		st <= 1'b1;
		pl <= n;
		@(posedge clk);
		st <= 1'b0;
		repeat (24) @(negedge clk);
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task t_reset;
		rdc(4'h1, 8'h00);
		chk({en, txo}, 8'h01);
		rdc(4'hC, 8'h01);
		rdc(4'h2, 8'h00);
	endtask
	task t_gate;
		wr8(4'h0, 8'h00);
		wr8(4'h1, 8'hC0);
		rdc(4'h1, 8'h00);
		wr8(4'h0, 8'h01);
		repeat (4) @(negedge clk);
		wr8(4'h1, 8'hC0);
		rdc(4'h1, 8'hC0);
		chk({en, csel}, 8'h03);
		wr8(4'h1, 8'h00);
		rdc(4'h1, 8'h80);
		chk({en, csel}, 8'h02);
		@(posedge clk);
		spec <= 1'b1;
		wr8(4'h1, 8'h00);
		rdc(4'h1, 8'h00);
		chk({7'h00, en}, 8'h00);
	endtask
	task t_modes;
		wr8(4'h1, 8'hA0);
		seteng(9'h021);
		chk({txo, eo.rx_bit, eo.ack_ignore}, 8'h05);
		// Remote node holds the bus dominant; loopback must not see it
		@(posedge clk);
		st <= 1'b1;
		pl <= 8'h30;
		seteng(9'h121);
		chk({txo, eo.rx_bit, bus}, 8'h06);
		@(posedge clk);
		st <= 1'b0;
		wr8(4'h1, 8'h90);
		chk({txo, eo.err_freeze, eo.tx_grant}, 8'h06);
		wr8(4'h1, 8'h80);
		seteng(9'h021);
		chk({txo, eo.err_freeze, eo.ack_ignore}, 8'h00);
	endtask
	task t_irq;
		wr8(4'h1, 8'hA0);
		seteng(9'h119);
		seteng(9'h101);
		rdc(4'hD, 8'h03);
		chk({7'h00, irq}, 8'h00);
		wr8(4'hE, 8'h01);
		chk({7'h00, irq}, 8'h01);
		wr8(4'hD, 8'h01);
		rdc(4'hD, 8'h02);
		chk({7'h00, irq}, 8'h00);
		wr8(4'hD, 8'h02);
		rdc(4'hD, 8'h00);
	endtask
	task t_seg;
		wr8(4'hF, 8'h03);
		chk({4'h0, eo.byte_count}, 8'h03);
		for (int i = 0; i < 8; i++) wr8(4'h4 + i[3:0], 8'hA0 + i[7:0]);
		for (int i = 0; i < 8; i++) rdc(4'h4 + i[3:0], 8'hA0 + i[7:0]);
		@(posedge clk);
		sw <= {1'b1, 3'h1, 8'h5A};
		@(posedge clk);
		sw <= {1'b1, 3'h5, 8'hC3};
		@(posedge clk);
		sw <= '0;
		rix <= 3'h1;
		@(negedge clk);
		@(negedge clk);
		chk(segd, 8'h5A);
		rdc(4'h5, 8'h5A);
		rdc(4'h9, 8'hA5);
		wr8(4'hF, 8'h0C);
		chk({4'h0, eo.byte_count}, 8'h08);
	endtask
	task t_wake;
		seteng(9'h101);
		wr8(4'h0, 8'h03);
		wr8(4'h1, 8'h84);
		@(posedge clk);
		slp <= 1'b1;
		n0 = nwk;
		pulse(8'h02);
		chk({7'h00, nwk > n0}, 8'h00);
		pulse(8'h0C);
		chk({7'h00, nwk > n0}, 8'h01);
		wr8(4'h1, 8'h80);
		n0 = nwk;
		pulse(8'h02);
		chk({7'h00, nwk > n0}, 8'h01);
		rdc(4'hD, 8'h04);
		@(posedge clk);
		slp <= 1'b0;
	endtask
	task t_boff;
		seteng(9'h105);
		wr8(4'h1, 8'h88);
		n0 = nrc;
		wr8(4'h0, 8'h07);
		repeat (3) @(negedge clk);
		chk({7'h00, nrc > n0}, 8'h01);
		wr8(4'h1, 8'h80);
		n0 = nrc;
		wr8(4'h0, 8'h07);
		repeat (3) @(negedge clk);
		chk({7'h00, nrc > n0}, 8'h00);
		n0 = nrc;
		seteng(9'h107);
		chk({7'h00, nrc > n0}, 8'h01);
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset;
		t_gate;
		t_modes;
		t_irq;
		t_seg;
		t_wake;
		t_boff;
		end_sim;
	end
	// Whole run is well under 3000 cycles
	initial begin
		#400000;
		err_total++;
		end_sim;
	end
endmodule
`default_nettype wire

// File: tb/cmc_node_model.sv
// Remote CAN node model driving dominant pulses onto a wired-AND bus
`timescale 1ns/10ps
`default_nettype none
module cmc_node_model (
	// Clock and control
	input wire logic i_mclk,
	input wire logic i_start,
	input wire logic [7:0] i_len,
	// Bus
	input wire logic i_dut_tx,
	output logic o_bus_level
);
	logic [7:0] cnt = 8'h00;
	always_ff @(posedge i_mclk) begin
		if (i_start) begin
			cnt <= i_len;
		end else if (cnt != 8'h00) begin
			cnt <= cnt - 8'h01;
		end
	end
	// Either node pulling low makes the bus dominant
	assign o_bus_level = i_dut_tx & (cnt == 8'h00);
endmodule
`default_nettype wire

// File: verilog/cmc_ctrl.sv
// CAN mode control, data segment bytes and interrupt logic behind an Avalon-MM slave
`timescale 1ns/10ps
`default_nettype none
`include "cmc_map.svh"

// What this block does
// - Enable bit: single write in normal modes, repeated writes in special modes during init.
// - Bit 7 enables the controller when 1, disables it when 0.
// - Bit 6 selects oscillator clock when 0, bus clock when 1.
// - Loopback: transmit fed to receiver, pin input ignored, pin held recessive.
// - Loopback: own frame received as remote, acknowledge slot bit disregarded.
// - Loopback still raises transmit and receive interrupts as normal.
// - Listen-only: frames received, no acknowledge or error frame driven.
// - Listen-only freezes transmit and receive error counters.
// - Listen-only never starts a frame transmission.
// - Bit 3 picks bus-off exit: automatic sequence when 0, software request when 1.
// - Bit 2 with wake-up enabled: any dominant level, or dominant pulse of wake time.
// - Eight data bytes per buffer; bytes used equal the data length code, capped at 8 for codes above 8.
// - Data bytes sit at indices 4 to B; content after reset undefined.
module cmc_ctrl
	import cmc_pkg::*;
#(
	parameter int WUP_CYC = `CMC_WUP_CYC
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_arst_n,
	// Avalon-MM slave
	input wire logic [5:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	// System
	input wire logic i_special_mode,
	input wire logic i_sleeping,
	output logic o_controller_enable,
	output logic o_clock_source_select,
	output logic o_irq,
	output logic o_wakeup,
	// Protocol engine
	input wire cmc_eng_in_t i_eng,
	output cmc_eng_out_t o_eng,
	input wire cmc_seg_wr_t i_seg_wr,
	input wire logic [2:0] i_seg_rd_index,
	output logic [7:0] o_seg_rd_data,
	// Bus pins
	input wire logic i_bus_receive_input,
	output logic o_bus_transmit_output
);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic is_seg(input logic [3:0] idx);
		return idx >= `CMC_IDX_SEG_FIRST && idx <= `CMC_IDX_SEG_LAST;
	endfunction
	function automatic logic [3:0] seg_count(input logic [3:0] code);
		return (code > `CMC_SEG_BYTES) ? `CMC_SEG_BYTES : code;
	endfunction
	// ------------------------------------------------------------
	// Bus slave: one wait cycle on every access
	// ------------------------------------------------------------
	logic ack_q;
	logic wr;
	logic [3:0] idx;
	assign o_waitrequest = (i_read | i_write) & ~ack_q;
	assign wr = i_write & ack_q;
	assign idx = i_address[5:2];
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (i_read | i_write) & ~ack_q;
		end
	end
	// ------------------------------------------------------------
	// mode_control_zero and init handshake
	// ------------------------------------------------------------
	logic init_request;
	logic wakeup_enable;
	logic init_acknowledge;
	logic sw_recov;
	logic in_init;
	assign in_init = init_request & init_acknowledge;
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			init_request <= 1'b1;
			wakeup_enable <= 1'b0;
		end else if (wr && idx == `CMC_IDX_CTL0) begin
			init_request <= i_writedata[`CMC_B_INIT_REQUEST];
			wakeup_enable <= i_writedata[`CMC_B_WAKEUP_ENABLE];
		end
	end

	// Ack waits for the engine to go idle so no frame is cut
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			init_acknowledge <= 1'b0;
		end else begin
			init_acknowledge <= init_request & (i_eng.idle | init_acknowledge);
		end
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sw_recov <= 1'b0;
		end else begin
			sw_recov <= wr && idx == `CMC_IDX_CTL0 && i_writedata[`CMC_B_RECOV];
		end
	end
	// ------------------------------------------------------------
	// mode_control_one
	// ------------------------------------------------------------
	logic [7:0] ctl1;
	logic en_locked;
	logic ctl1_wr;
	logic loop_m;
	logic listen_m;
	assign ctl1_wr = wr && idx == `CMC_IDX_CTL1 && in_init;
	assign loop_m = ctl1[`CMC_B_LOOP];
	assign listen_m = ctl1[`CMC_B_LISTEN];
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ctl1 <= `CMC_CTL1_RESET;
		end else if (ctl1_wr) begin
			ctl1[6:2] <= i_writedata[6:2];
			if (i_special_mode || !en_locked) begin
				ctl1[`CMC_B_ENABLE] <= i_writedata[`CMC_B_ENABLE];
			end
		end
	end

	// Write-once lock only counts in normal modes
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			en_locked <= 1'b0;
		end else if (ctl1_wr && !i_special_mode) begin
			en_locked <= 1'b1;
		end
	end

	assign o_controller_enable = ctl1[`CMC_B_ENABLE];
	assign o_clock_source_select = ctl1[`CMC_B_CLOCK_SOURCE_SELECT];
	// ------------------------------------------------------------
	// Receive pin synchroniser
	// ------------------------------------------------------------
	logic rx_s1;
	logic rx_s2;
	logic rx_s3;
	logic rx_lvl;
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
			rx_s3 <= 1'b1;
			rx_lvl <= 1'b1;
		end else begin
			rx_s1 <= i_bus_receive_input;
			rx_s2 <= rx_s1;
			rx_s3 <= rx_s2;
			if (rx_s2 == rx_s3) begin
				rx_lvl <= rx_s3;
			end
		end
	end
	// ------------------------------------------------------------
	// Bit routing and mode gating
	// ------------------------------------------------------------
	// Listen-only forces recessive so ack and error frames never leave
	assign o_bus_transmit_output = (loop_m | listen_m | ~o_controller_enable) ? 1'b1 : i_eng.tx_bit;
	assign o_eng.rx_bit = loop_m ? i_eng.tx_bit : rx_lvl;
	assign o_eng.ack_ignore = loop_m;
	assign o_eng.err_freeze = listen_m;
	assign o_eng.tx_grant = i_eng.tx_start_req & ~listen_m & o_controller_enable;
	assign o_eng.recover = i_eng.bus_off & (ctl1[`CMC_B_BUS_OFF_RECOVERY_POLICY] ? sw_recov : i_eng.auto_recov_ok);
	// ------------------------------------------------------------
	// Data segment bytes and length code
	// ------------------------------------------------------------
	logic [7:0] seg [8];
	logic [3:0] dlc;
	logic [3:0] nbytes;
	assign nbytes = seg_count(dlc);
	assign o_eng.byte_count = nbytes;

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			dlc <= 4'h0;
		end else if (wr && idx == `CMC_IDX_DLC) begin
			dlc <= i_writedata[3:0];
		end
	end

	// No reset: payload content is undefined after reset
	always_ff @(posedge i_mclk) begin
		if (wr && is_seg(idx)) begin
			seg[idx[2:0] ^ 3'h4] <= i_writedata[7:0];
		end else if (i_seg_wr.wr && {1'b0, i_seg_wr.index} < nbytes) begin
			seg[i_seg_wr.index] <= i_seg_wr.data;
		end
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_seg_rd_data <= 8'h00;
		end else begin
			o_seg_rd_data <= seg[i_seg_rd_index];
		end
	end
	// ------------------------------------------------------------
	// Wake-up detection
	// ------------------------------------------------------------
	logic [15:0] wup_cnt;
	logic wake_evt;
	logic wake_armed;
	assign wake_armed = wakeup_enable & i_sleeping & ~rx_lvl;
	assign wake_evt = wake_armed & (ctl1[`CMC_B_WAKEUP_FILTER_SELECT] ? (wup_cnt == 16'(WUP_CYC - 1)) : (wup_cnt == 16'h0000));

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wup_cnt <= 16'h0000;
		end else if (!wake_armed) begin
			wup_cnt <= 16'h0000;
		end else if (wup_cnt != 16'hFFFF) begin
			wup_cnt <= wup_cnt + 16'h0001;
		end
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_wakeup <= 1'b0;
		end else begin
			o_wakeup <= wake_evt;
		end
	end
	// ------------------------------------------------------------
	// Interrupts: sticky status, write one to clear, set wins
	// ------------------------------------------------------------
	logic [3:0] irq_stat;
	logic [3:0] irq_mask;
	logic [3:0] irq_set;
	logic [3:0] irq_clr;
	logic boff_q;

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			boff_q <= 1'b0;
		end else begin
			boff_q <= i_eng.bus_off;
		end
	end

	// Loopback does not gate the frame events
	assign irq_set = {i_eng.bus_off & ~boff_q, wake_evt, i_eng.rx_done, i_eng.tx_done};
	assign irq_clr = (wr && idx == `CMC_IDX_IRQ) ? i_writedata[3:0] : 4'h0;

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			irq_stat <= 4'h0;
		end else begin
			irq_stat <= (irq_stat & ~irq_clr) | irq_set;
		end
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			irq_mask <= 4'h0;
		end else if (wr && idx == `CMC_IDX_MASK) begin
			irq_mask <= i_writedata[3:0];
		end
	end

	assign o_irq = |(irq_stat & irq_mask);
	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	logic [7:0] rd_val;
	always_comb begin
		rd_val = 8'h00;
		if (is_seg(idx)) begin
			rd_val = seg[idx[2:0] ^ 3'h4]; // Index 4 holds byte 0
		end else begin
			unique case (idx)
				`CMC_IDX_CTL0: rd_val = {6'h00, wakeup_enable, init_request};
				`CMC_IDX_CTL1: rd_val = ctl1;
				`CMC_IDX_STAT: rd_val = {4'h0, en_locked, i_special_mode, i_eng.bus_off, init_acknowledge};
				`CMC_IDX_IRQ: rd_val = {4'h0, irq_stat};
				`CMC_IDX_MASK: rd_val = {4'h0, irq_mask};
				`CMC_IDX_DLC: rd_val = {4'h0, dlc};
				default: rd_val = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_readdata <= 32'h00000000;
		end else if (i_read && !ack_q) begin
			o_readdata <= {24'h000000, rd_val};
		end
	end
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_arst_n);
	a_ctl1_gate_closed: assert property (wr && idx == `CMC_IDX_CTL1 && !in_init |=> $stable(ctl1))
		else $error("mode control changed outside init");
	a_enable_once: assert property (en_locked && !i_special_mode |=> $stable(o_controller_enable))
		else $error("enable rewritten in normal mode");
	a_enable_follows: assert property (ctl1_wr && (i_special_mode || !en_locked)
		|=> o_controller_enable == $past(i_writedata[`CMC_B_ENABLE]))
		else $error("enable bit not stored");
	a_clock_select: assert property (ctl1_wr |=> o_clock_source_select == $past(i_writedata[`CMC_B_CLOCK_SOURCE_SELECT]))
		else $error("clock source not stored");
	a_loop_route: assert property (loop_m |-> o_bus_transmit_output && o_eng.rx_bit == i_eng.tx_bit)
		else $error("loopback routing broken");
	a_listen_quiet: assert property (listen_m |-> o_bus_transmit_output && !o_eng.tx_grant && o_eng.err_freeze)
		else $error("listen-only drove the bus");
	a_recover_policy: assert property (i_eng.bus_off && !ctl1[`CMC_B_BUS_OFF_RECOVERY_POLICY] |-> o_eng.recover == i_eng.auto_recov_ok)
		else $error("automatic recovery not followed");
	a_wake_filter: assert property (wakeup_enable && ctl1[`CMC_B_WAKEUP_FILTER_SELECT] && $rose(wake_armed) && WUP_CYC > 1
		|-> !wake_evt)
		else $error("filtered wake fired on first cycle");
	a_irq_sticky: assert property (i_eng.rx_done |=> irq_stat[`CMC_IRQ_RX]
		##1 (irq_stat[`CMC_IRQ_RX] || $past(irq_clr[`CMC_IRQ_RX])))
		else $error("receive event lost");
	a_bytes_cap: assert property (o_eng.byte_count <= `CMC_SEG_BYTES && (dlc > 4'h8 || o_eng.byte_count == dlc))
		else $error("byte count wrong");
	a_bus_answer: assert property ((i_read || i_write) && !ack_q |=> !o_waitrequest)
		else $error("bus access not answered");
	c_loop_tx: cover property (loop_m && i_eng.tx_done ##[1:20] i_eng.rx_done);
	c_listen_rx: cover property (listen_m && i_eng.rx_done);
	c_sw_recover: cover property (ctl1[`CMC_B_BUS_OFF_RECOVERY_POLICY] && o_eng.recover);
	c_wake: cover property (o_wakeup);
endmodule
`default_nettype wire

// File: verilog/cmc_map.svh
// Register offsets, field positions, reset values and timing counts of the CAN mode block
`ifndef CMC_MAP_SVH
`define CMC_MAP_SVH
// ------------------------------------------------------------
// Register indices (byte address = 4 * index)
// ------------------------------------------------------------
`define CMC_IDX_CTL0 4'h0
`define CMC_IDX_CTL1 4'h1
`define CMC_IDX_SEG_FIRST 4'h4
`define CMC_IDX_SEG_LAST 4'hB
`define CMC_IDX_STAT 4'hC
`define CMC_IDX_IRQ 4'hD
`define CMC_IDX_MASK 4'hE
`define CMC_IDX_DLC 4'hF
// ------------------------------------------------------------
// mode_control_one fields
// ------------------------------------------------------------
`define CMC_B_ENABLE 7
`define CMC_B_CLOCK_SOURCE_SELECT 6
`define CMC_B_LOOP 5
`define CMC_B_LISTEN 4
`define CMC_B_BUS_OFF_RECOVERY_POLICY 3
`define CMC_B_WAKEUP_FILTER_SELECT 2
`define CMC_CTL1_RESET 8'h00
// ------------------------------------------------------------
// mode_control_zero, status and interrupt fields
// ------------------------------------------------------------
`define CMC_B_INIT_REQUEST 0
`define CMC_B_WAKEUP_ENABLE 1
`define CMC_B_RECOV 2
`define CMC_B_INIT_ACKNOWLEDGE 0
`define CMC_B_BUSOFF 1
`define CMC_B_SPECIAL 2
`define CMC_B_ENLOCK 3
`define CMC_IRQ_TX 0
`define CMC_IRQ_RX 1
`define CMC_IRQ_WAKE 2
`define CMC_IRQ_BOFF 3
`define CMC_SEG_BYTES 4'h8
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CMC_CLK_NS 40
`define CMC_T_WUP_NS 2000
`define CMC_WUP_CYC ((`CMC_T_WUP_NS + `CMC_CLK_NS - 1) / `CMC_CLK_NS)
`endif

// File: verilog/cmc_pkg.sv
// Types shared between the CAN mode block and its protocol engine
package cmc_pkg;
	typedef struct packed {
		logic tx_bit;
		logic ack_drive;
		logic err_drive;
		logic tx_start_req;
		logic tx_done;
		logic rx_done;
		logic bus_off;
		logic auto_recov_ok;
		logic idle;
	} cmc_eng_in_t;
	typedef struct packed {
		logic rx_bit;
		logic ack_ignore;
		logic err_freeze;
		logic tx_grant;
		logic recover;
		logic [3:0] byte_count;
	} cmc_eng_out_t;
	typedef struct packed {
		logic wr;
		logic [2:0] index;
		logic [7:0] data;
	} cmc_seg_wr_t;
endpackage
